// file: dsm_pkg.sv
// package: register map, status coil layout, request and answer carriers
package dsm_pkg;

   // register word width and bus address width
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 16;

   // holding register bus addresses (zero based, one below register number)
   localparam logic [15:0] ADDR_LEGACY_SLOT_A       = 16'h0000;
   localparam logic [15:0] ADDR_LEGACY_SLOT_B       = 16'h0001;
   localparam logic [15:0] ADDR_LEGACY_SLOT_C       = 16'h0002;
   localparam logic [15:0] ADDR_FREE_SLOT_A         = 16'h0003;
   localparam logic [15:0] ADDR_FREE_SLOT_B         = 16'h0004;
   localparam logic [15:0] ADDR_BUS_CONFIGURATION   = 16'h0005;
   localparam logic [15:0] ADDR_LAST_FAULT_CODE     = 16'h0006;
   localparam logic [15:0] ADDR_LAST_ERROR_ADDRESS  = 16'h0007;
   localparam logic [15:0] ADDR_ARRAY_INDEX_POINTER = 16'h0008;
   localparam logic [15:0] ADDR_LANGUAGE_SETTING    = 16'h0009;
   localparam logic [15:0] ADDR_SPEED_UNIT_SETTING  = 16'h0013;
   localparam logic [15:0] ADDR_REGIONAL_SETTING    = 16'h001d;

   // parameter slots: register number = 10 x parameter number
   localparam logic [15:0] PARAM_REG_STRIDE  = 16'h000a;
   localparam int unsigned PARAM_SLOT_BYTES  = 20;
   localparam logic [15:0] REG_NUMBER_OFFSET = 16'h0001;

   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;

   // bus configuration field: persist stored data values
   localparam int unsigned CFG_PERSIST_BIT = 0;

   // status word bit positions (coil number minus 33)
   localparam int unsigned COIL_BASE          = 33;
   localparam int unsigned SB_CONTROL_READY   = 0;
   localparam int unsigned SB_CONVERTER_READY = 1;
   localparam int unsigned SB_SAFETY_CLOSED   = 2;
   localparam int unsigned SB_ALARM           = 3;
   localparam int unsigned SB_UNUSED_37       = 4;
   localparam int unsigned SB_UNUSED_38       = 5;
   localparam int unsigned SB_UNUSED_39       = 6;
   localparam int unsigned SB_WARNING         = 7;
   localparam int unsigned SB_AT_REFERENCE    = 8;
   localparam int unsigned SB_AUTO_MODE       = 9;
   localparam int unsigned SB_IN_FREQ_RANGE   = 10;
   localparam int unsigned SB_RUNNING         = 11;
   localparam int unsigned SB_UNUSED_45       = 12;
   localparam int unsigned SB_VOLTAGE_WARNING = 13;
   localparam int unsigned SB_CURRENT_LIMIT   = 14;
   localparam int unsigned SB_THERMAL_WARNING = 15;

   // converter condition levels feeding the status word
   typedef struct packed {
      logic control_ready;
      logic converter_ready;
      logic safety_closed;
      logic alarm;
      logic warning;
      logic at_reference;
      logic auto_mode;
      logic running;
      logic voltage_warning;
      logic current_limit;
      logic thermal_warning;
   } dsm_cond_t;

   // holding register request from the telegram decoder
   typedef struct packed {
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dsm_req_t;

   // answer to the telegram decoder
   typedef struct packed {
      logic [15:0] rdata;
      logic        error;
   } dsm_rsp_t;

   // access forwarded to the parameter database
   typedef struct packed {
      logic        write;
      logic [15:0] parameter_number;
      logic [3:0]  word_offset;
      logic [15:0] index;
      logic [15:0] wdata;
   } dsm_par_req_t;

   // answer from the parameter database
   typedef struct packed {
      logic [15:0] rdata;
      logic        denied;
      logic        fault;
      logic [15:0] fault_code;
   } dsm_par_rsp_t;

   // request handling states
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b01,
      ST_PAR_WAIT = 2'b10
   } dsm_state_t;

endpackage

// file: dsm_status_word.sv
// status word builder: synchronised conditions and frequency range compare
`timescale 1ns/100ps
module dsm_status_word
   import dsm_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // converter conditions, asynchronous to sys_clk
   input  wire dsm_cond_t   cond,
   // output frequency and configured range, same clock
   input  wire logic [15:0] out_freq,
   input  wire logic [15:0] freq_low,
   input  wire logic [15:0] freq_high,
   // assembled status word, coil 33 in bit 0
   output logic [15:0]      status_word
);

   dsm_cond_t   sync1_reg;
   dsm_cond_t   sync1_next;
   dsm_cond_t   sync2_reg;
   dsm_cond_t   sync2_next;
   logic [15:0] word_reg;
   logic [15:0] word_next;

   // two-stage synchroniser; stage one feeds only stage two
   always_comb
   begin
      sync1_next = cond;
      sync2_next = sync1_reg;
   end

   // word assembly: conditions from the second stage, frequency range straight from the inputs
   always_comb
   begin
      word_next                     = RST_WORD;
      word_next[SB_CONTROL_READY]   = sync2_reg.control_ready;   // [RULE_01]
      word_next[SB_CONVERTER_READY] = sync2_reg.converter_ready; // [RULE_01]
      word_next[SB_SAFETY_CLOSED]   = sync2_reg.safety_closed;   // [RULE_01]
      word_next[SB_ALARM]           = sync2_reg.alarm;           // [RULE_01]
      word_next[SB_WARNING]         = sync2_reg.warning;         // [RULE_01]
      word_next[SB_AT_REFERENCE]    = sync2_reg.at_reference;    // [RULE_01]
      word_next[SB_AUTO_MODE]       = sync2_reg.auto_mode;       // [RULE_01]
      word_next[SB_RUNNING]         = sync2_reg.running;         // [RULE_01]
      word_next[SB_VOLTAGE_WARNING] = sync2_reg.voltage_warning; // [RULE_02]
      word_next[SB_CURRENT_LIMIT]   = sync2_reg.current_limit;   // [RULE_02]
      word_next[SB_THERMAL_WARNING] = sync2_reg.thermal_warning; // [RULE_02]
      // inclusive range; an inverted range never reports in range
      word_next[SB_IN_FREQ_RANGE]   = (out_freq >= freq_low) && (out_freq <= freq_high); // [RULE_03]
      // coils 37, 38, 39 and 45 stay zero from the default above
      word_next[SB_UNUSED_37]       = 1'b0; // [RULE_04]
      word_next[SB_UNUSED_38]       = 1'b0; // [RULE_04]
      word_next[SB_UNUSED_39]       = 1'b0; // [RULE_04]
      word_next[SB_UNUSED_45]       = 1'b0; // [RULE_04]
   end

   // state registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         word_reg  <= RST_WORD;
      end
      else
      begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         word_reg  <= word_next;
      end
   end

   assign status_word = word_reg;

endmodule // dsm_status_word

// file: dsm_register_map.sv
// converter status word and low holding register map for the serial bus slave
//
// Contract
// [RULE_01] Status coils 33, 34, 35, 36, 40, 41, 42 and 44 read one while ready, ready, safety, alarm, warning, reference, auto and running hold.
// [RULE_02] Coils 46, 47 and 48 follow the voltage warning, current limit and thermal warning conditions.
// [RULE_03] Coil 43 reads one only while output frequency lies inside the configured range.
// [RULE_04] Coils 37, 38, 39 and 45 always read zero and any value written to them is dropped.
// [RULE_05] The master sends a bus address one below the register number it means.
// [RULE_06] Bus addresses 0 to 4 are legacy or free slots with no function behind them.
// [RULE_07] Bus address 5 is a read/write bus configuration word that selects persistent storage.
// [RULE_08] Bus address 6 reads back the latest fault code from the parameter database.
// [RULE_09] Bus address 7 reads back the address of the access that last failed.
// [RULE_10] Bus address 8 is a read/write index pointer that selects the array sub-index.
// [RULE_11] A parameter sits at register number ten times its number with its own access rights.
// [RULE_12] Each parameter owns a 20-byte slot, so slots start at bus addresses 9, 19 and 29.
// [RULE_13] The sixteen coils 33 to 48 form the status word sent from slave to master.
// [RULE_14] The master writes the index pointer before touching an array parameter.
`timescale 1ns/100ps
module dsm_register_map
   import dsm_pkg::*;
(
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // converter conditions and frequency range
   input  wire dsm_cond_t    cond,
   input  wire logic [15:0]  out_freq,
   input  wire logic [15:0]  freq_low,
   input  wire logic [15:0]  freq_high,
   // holding register requests from the telegram decoder
   input  wire logic         req_valid,
   input  wire dsm_req_t     req,
   output logic              req_ready,
   // answers to the telegram decoder
   output logic              rsp_valid,
   output dsm_rsp_t          rsp,
   // parameter database access
   output logic              par_req_valid,
   output dsm_par_req_t      par_req,
   input  wire logic         par_rsp_valid,
   input  wire dsm_par_rsp_t par_rsp,
   // status word and persistence level
   output logic [15:0]       status_word,
   output logic              store_persistent
);

   // slot decode result for a parameter address
   typedef struct packed {
      logic        hit;
      logic [15:0] parameter_number;
      logic [3:0]  word_offset;
   } dsm_slot_t;

   dsm_state_t   state_reg;
   dsm_state_t   state_next;
   logic         ready_reg;
   logic         ready_next;
   logic         rsp_valid_reg;
   logic         rsp_valid_next;
   dsm_rsp_t     rsp_reg;
   dsm_rsp_t     rsp_next;
   logic         par_valid_reg;
   logic         par_valid_next;
   dsm_par_req_t par_reg;
   dsm_par_req_t par_next;
   logic [15:0]  cfg_reg;
   logic [15:0]  cfg_next;
   logic [15:0]  fault_reg;
   logic [15:0]  fault_next;
   logic [15:0]  err_addr_reg;
   logic [15:0]  err_addr_next;
   logic [15:0]  index_reg;
   logic [15:0]  index_next;
   logic [15:0]  pend_addr_reg;
   logic [15:0]  pend_addr_next;
   logic [15:0]  status_word_w;
   logic         persist_reg;
   logic         persist_next;
   dsm_slot_t    slot;
   logic         take;

   // status coils are built in their own module
   dsm_status_word u_status_word (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .cond        (cond),
      .out_freq    (out_freq),
      .freq_low    (freq_low),
      .freq_high   (freq_high),
      .status_word (status_word_w)
   );

   // bus address to parameter slot; the address already sits one below the register number
   function automatic dsm_slot_t slot_decode(input logic [15:0] addr);
      logic [16:0] reg_number;
      dsm_slot_t   s;
      reg_number         = {1'b0, addr} + {1'b0, REG_NUMBER_OFFSET}; // [RULE_05]
      s.hit              = (addr >= ADDR_LANGUAGE_SETTING);
      // 20-byte slot is ten words: word 0 at 10 x number, so slot k starts at 10k-1
      s.parameter_number = 16'(reg_number / 17'(PARAM_REG_STRIDE)); // [RULE_11] [RULE_12]
      s.word_offset      = 4'(reg_number % 17'(PARAM_REG_STRIDE));  // [RULE_12]
      return s;
   endfunction

   assign slot = slot_decode(req.addr);
   assign take = req_valid && ready_reg;

   // request handling, map decode and register updates
   always_comb
   begin
      state_next     = state_reg;
      ready_next     = ready_reg;
      rsp_valid_next = 1'b0;
      rsp_next       = rsp_reg;
      par_valid_next = 1'b0;
      par_next       = par_reg;
      cfg_next       = cfg_reg;
      fault_next     = fault_reg;
      err_addr_next  = err_addr_reg;
      index_next     = index_reg;
      pend_addr_next = pend_addr_reg;
      persist_next   = cfg_reg[CFG_PERSIST_BIT]; // [RULE_07]
      case (state_reg)
         ST_IDLE:
         begin
            ready_next = 1'b1;
            if (take)
            begin
               rsp_valid_next = 1'b1;
               rsp_next.rdata = RST_WORD;
               rsp_next.error = 1'b0;
               if (req.addr <= ADDR_FREE_SLOT_B)
               begin
                  // legacy and free slots: read zero, writes dropped, no error
                  rsp_next.rdata = RST_WORD; // [RULE_06]
               end
               else if (req.addr == ADDR_BUS_CONFIGURATION)
               begin
                  if (req.write)
                     cfg_next = req.wdata; // [RULE_07]
                  rsp_next.rdata = req.write ? req.wdata : cfg_reg; // [RULE_07]
               end
               else if (req.addr == ADDR_LAST_FAULT_CODE)
               begin
                  // read only: a write is refused and recorded
                  rsp_next.rdata = fault_reg; // [RULE_08]
                  rsp_next.error = req.write;
                  if (req.write)
                     err_addr_next = req.addr; // [RULE_09]
               end
               else if (req.addr == ADDR_LAST_ERROR_ADDRESS)
               begin
                  rsp_next.rdata = err_addr_reg; // [RULE_09]
                  rsp_next.error = req.write;
                  if (req.write)
                     err_addr_next = req.addr; // [RULE_09]
               end
               else if (req.addr == ADDR_ARRAY_INDEX_POINTER)
               begin
                  // pointer holds until rewritten, so it covers all later array accesses
                  if (req.write)
                     index_next = req.wdata; // [RULE_10] [RULE_14]
                  rsp_next.rdata = req.write ? req.wdata : index_reg; // [RULE_10]
               end
               else if (slot.hit)
               begin
                  // access rights belong to the parameter; the database decides
                  rsp_valid_next            = 1'b0;
                  ready_next                = 1'b0;
                  par_valid_next            = 1'b1;
                  par_next.write            = req.write; // [RULE_11]
                  par_next.parameter_number = slot.parameter_number; // [RULE_11]
                  par_next.word_offset      = slot.word_offset; // [RULE_12]
                  par_next.index            = index_reg; // [RULE_10]
                  par_next.wdata            = req.wdata;
                  pend_addr_next            = req.addr;
                  state_next                = ST_PAR_WAIT;
               end
            end
         end
         ST_PAR_WAIT:
         begin
            ready_next = 1'b0;
            // no timeout: the database must always answer
            if (par_rsp_valid)
            begin
               rsp_valid_next = 1'b1;
               rsp_next.rdata = par_rsp.denied ? RST_WORD : par_rsp.rdata; // [RULE_11]
               rsp_next.error = par_rsp.denied || par_rsp.fault; // [RULE_11]
               if (par_rsp.fault)
                  fault_next = par_rsp.fault_code; // [RULE_08]
               if (par_rsp.denied || par_rsp.fault)
                  err_addr_next = pend_addr_reg; // [RULE_09]
               ready_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
            ready_next = 1'b0;
         end
      endcase
   end

   // state registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_reg     <= ST_IDLE;
         ready_reg     <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_reg       <= '0;
         par_valid_reg <= 1'b0;
         par_reg       <= '0;
         cfg_reg       <= RST_WORD;
         fault_reg     <= RST_WORD;
         err_addr_reg  <= RST_WORD;
         index_reg     <= RST_WORD;
         pend_addr_reg <= RST_WORD;
         persist_reg   <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         ready_reg     <= ready_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_reg       <= rsp_next;
         par_valid_reg <= par_valid_next;
         par_reg       <= par_next;
         cfg_reg       <= cfg_next;
         fault_reg     <= fault_next;
         err_addr_reg  <= err_addr_next;
         index_reg     <= index_next;
         pend_addr_reg <= pend_addr_next;
         persist_reg   <= persist_next;
      end
   end

   // outputs straight from flops
   assign req_ready        = ready_reg;
   assign rsp_valid        = rsp_valid_reg;
   assign rsp              = rsp_reg;
   assign par_req_valid    = par_valid_reg;
   assign par_req          = par_reg;
   assign status_word      = status_word_w; // [RULE_13]
   assign store_persistent = persist_reg;

endmodule // dsm_register_map

// file: dsm_register_map_asserts.sv
// checker: status word and register map properties at the top ports
`timescale 1ns/100ps
module dsm_register_map_asserts
   import dsm_pkg::*;
(
   // clock and reset
   input wire logic         sys_clk,
   input wire logic         rst_n,
   // inputs of the block
   input wire dsm_cond_t    cond,
   input wire logic [15:0]  out_freq,
   input wire logic [15:0]  freq_low,
   input wire logic [15:0]  freq_high,
   input wire logic         req_valid,
   input wire dsm_req_t     req,
   input wire logic         par_rsp_valid,
   input wire dsm_par_rsp_t par_rsp,
   // outputs of the block
   input wire logic         req_ready,
   input wire logic         rsp_valid,
   input wire dsm_rsp_t     rsp,
   input wire logic         par_req_valid,
   input wire dsm_par_req_t par_req,
   input wire logic [15:0]  status_word,
   input wire logic         store_persistent
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // helper terms; conditions pass two sync flops and one register
   wire        take   = req_valid && req_ready;
   wire [15:0] rnum   = req.addr + 16'h0001;
   wire        wd0    = req.wdata[0];
   wire        in_rng = (out_freq >= freq_low) && (out_freq <= freq_high);
   wire        ro_hit = (req.addr == 16'h0006) || (req.addr == 16'h0007);
   wire [7:0]  c_one  = {cond.running, cond.auto_mode, cond.at_reference, cond.warning,
                         cond.alarm, cond.safety_closed, cond.converter_ready, cond.control_ready};
   wire [2:0]  c_two  = {cond.thermal_warning, cond.current_limit, cond.voltage_warning};
   wire [7:0]  s_one  = {status_word[11], status_word[9:7], status_word[3:0]};

   unused_zero_a: assert property (status_word[6:4] == 3'h0 && !status_word[12])
      else $error("unused coil not zero");
   status_main_a: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |-> s_one == $past(c_one, 3))
      else $error("status coil does not follow condition");
   status_warn_a: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |-> status_word[15:13] == $past(c_two, 3))
      else $error("warning coil does not follow condition");
   freq_range_a: assert property ($past(rst_n) |-> status_word[10] == $past(in_rng))
      else $error("frequency range coil wrong");
   local_answer_a: assert property (take && req.addr < 16'h0009 |=> rsp_valid)
      else $error("local answer missing");
   reserved_zero_a: assert property (take && !req.write && req.addr < 16'h0005 |=> !rsp.error && rsp.rdata == 16'h0000)
      else $error("reserved slot not zero");
   ro_write_err_a: assert property (take && req.write && ro_hit |=> rsp_valid && rsp.error)
      else $error("read only write not refused");
   persist_bit_a: assert property (take && req.write && req.addr == 16'h0005 |=> ##1 store_persistent == $past(wd0, 2))
      else $error("persist level wrong");
   par_map_a: assert property (take && req.addr >= 16'h0009 |=> par_req_valid
      && par_req.write == $past(req.write) && par_req.wdata == $past(req.wdata)
      && par_req.parameter_number == $past(rnum) / 16'h000a && {12'h000, par_req.word_offset} == $past(rnum) % 16'h000a)
      else $error("parameter slot mapping wrong");
   par_wait_a: assert property (par_req_valid |-> !req_ready)
      else $error("ready high during parameter wait");
   par_answer_a: assert property (par_rsp_valid && !req_ready |=> rsp_valid)
      else $error("parameter answer missing");

   // main scenarios
   par_cover_c: cover property (par_req_valid ##[1:5] par_rsp_valid);
   ro_cover_c: cover property (take && req.write && ro_hit);
   fault_cover_c: cover property (par_rsp_valid && par_rsp.fault);
endmodule // dsm_register_map_asserts

bind dsm_register_map dsm_register_map_asserts i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .cond(cond),
   .out_freq(out_freq), .freq_low(freq_low), .freq_high(freq_high), .req_valid(req_valid), .req(req),
   .par_rsp_valid(par_rsp_valid), .par_rsp(par_rsp), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
   .par_req_valid(par_req_valid), .par_req(par_req), .status_word(status_word), .store_persistent(store_persistent));

// file: dsm_par_db_model.sv
// parameter database model answering forwarded parameter accesses
`timescale 1ns/100ps
module dsm_par_db_model
   import dsm_pkg::*;
#(
   parameter logic [15:0] FAULT_CODE = 16'h0c3e
)
(
   // clock
   input  wire logic         sys_clk,
   // access from the register map
   input  wire logic         par_req_valid,
   input  wire dsm_par_req_t par_req,
   // answer
   output logic              par_rsp_valid,
   output dsm_par_rsp_t      par_rsp
);
   dsm_par_req_t r;
   int           n;

   initial
   begin
      par_rsp_valid = 1'b0;
      par_rsp       = '0;
   end

   // answer after a random stall; parameter 3 is read only, parameter 4 faults
   always
   begin
      @(posedge sys_clk);
      if (par_req_valid === 1'b1)
      begin
         r = par_req;
         n = $urandom_range(3, 0);
         repeat (n) @(posedge sys_clk);
         #2;
         par_rsp_valid      = 1'b1;
         par_rsp.denied     = r.write && r.parameter_number == 16'h0003;
         par_rsp.fault      = r.parameter_number == 16'h0004;
         par_rsp.fault_code = FAULT_CODE;
         par_rsp.rdata      = {r.parameter_number[7:0], r.index[3:0], r.word_offset};
         @(posedge sys_clk);
         #2;
         par_rsp_valid = 1'b0;
         par_rsp       = ~par_rsp; // stale answer lines carry no meaning
      end
   end
endmodule // dsm_par_db_model

// file: drive_status_and_register_map_tb_top.sv
// testbench: register map and status word against a database model
`timescale 1ns/100ps
module drive_status_and_register_map_tb_top
   import dsm_pkg::*;
();
   localparam logic [15:0] FAULT = 16'h0c3e;
   logic         sys_clk, rst_n, req_valid, par_rsp_valid;
   logic         req_ready, rsp_valid, par_req_valid, store_persistent;
   dsm_cond_t    cond;
   dsm_req_t     req;
   dsm_rsp_t     rsp, e;
   dsm_par_req_t par_req;
   dsm_par_rsp_t par_rsp;
   logic [15:0]  out_freq, freq_low, freq_high, status_word, v, x, f;
   logic         m;
   int           fail_count, comparisons;
   dsm_rsp_t     exp_q[$];
   logic         mask_q[$];
   logic [15:0]  pa[4] = '{16'h0009, 16'h000a, 16'h0013, 16'h001d};

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   dsm_register_map i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cond(cond), .out_freq(out_freq),
      .freq_low(freq_low), .freq_high(freq_high), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .par_req_valid(par_req_valid), .par_req(par_req),
      .par_rsp_valid(par_rsp_valid), .par_rsp(par_rsp), .status_word(status_word),
      .store_persistent(store_persistent));

   dsm_par_db_model #(.FAULT_CODE(FAULT)) i_db (.sys_clk(sys_clk), .par_req_valid(par_req_valid),
      .par_req(par_req), .par_rsp_valid(par_rsp_valid), .par_rsp(par_rsp));

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // expected database word: parameter number, index, word offset
   function automatic logic [15:0] pexp(input logic [15:0] a, input logic [15:0] i);
      logic [15:0] r;
      r = a + 16'h0001;
      return {8'(r / 16'h000a), i[3:0], 4'(r % 16'h000a)};
   endfunction

   task automatic idle;
      req_valid = 1'b0;
      @(posedge sys_clk);
      #2;
   endtask

   // one request, held until taken; mk selects whether read data is compared
   task automatic acc(input logic w, input logic [15:0] a, d, er, input logic ee, input logic mk);
      int n;
      req_valid = 1'b1;
      req       = '{w, a, d};
      n         = 0;
      while (req_ready !== 1'b1 && n < 40)
      begin
         @(posedge sys_clk);
         #2;
         n++;
      end
      @(posedge sys_clk);
      exp_q.push_back(dsm_rsp_t'{er, ee});
      mask_q.push_back(mk);
      #2;
      if (a >= 16'h0009)
      begin
         req_valid = 1'b0; // no second take while the database answers
         n = 0;
         while (rsp_valid !== 1'b1 && n < 40)
         begin
            @(posedge sys_clk);
            #2;
            n++;
         end
      end
   endtask

   // conditions settle through two sync flops and a register
   task automatic stat(input logic [15:0] fr);
      logic [15:0] ew;
      cond     = dsm_cond_t'(11'($urandom()));
      out_freq = fr;
      repeat (4) @(posedge sys_clk);
      #2;
      ew = {cond.thermal_warning, cond.current_limit, cond.voltage_warning, 1'b0, cond.running,
            fr >= freq_low && fr <= freq_high, cond.auto_mode, cond.at_reference, cond.warning, 3'h0,
            cond.alarm, cond.safety_closed, cond.converter_ready, cond.control_ready};
      check(status_word === ew, "status word mismatch");
   endtask

   // answer watcher: oldest note against each answer
   always @(posedge sys_clk)
   begin
      if (rsp_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(1'b0, "answer without request");
         else
         begin
            e = exp_q.pop_front();
            m = mask_q.pop_front();
            check(rsp.error === e.error && (!m || rsp.rdata === e.rdata), "answer mismatch");
         end
      end
   end

   initial
   begin
      #(25 * 20000);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end

   initial
   begin
      void'($urandom(32'h668a39a1));
      rst_n     = 1'b0;
      req_valid = 1'b0;
      req       = '0;
      cond      = '0;
      out_freq  = 16'h0000;
      freq_low  = 16'h0100;
      freq_high = 16'h0200;
      repeat (12) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      for (int a = 5; a < 9; a++) acc(1'b0, 16'(a), 16'h0000, 16'h0000, 1'b0, 1'b1);
      for (int a = 0; a < 5; a++) acc(1'b1, 16'(a), 16'($urandom()), 16'h0000, 1'b0, 1'b1);
      for (int a = 0; a < 5; a++) acc(1'b0, 16'(a), 16'h0000, 16'h0000, 1'b0, 1'b1);
      for (int i = 0; i < 2; i++)
      begin
         v    = 16'($urandom());
         v[0] = i[0];
         acc(1'b1, 16'h0005, v, v, 1'b0, 1'b1);
         acc(1'b0, 16'h0005, 16'h0000, v, 1'b0, 1'b1);
         idle();
         check(store_persistent === v[0], "persist level mismatch");
         x = i ? 16'($urandom()) : 16'h0002;
         acc(1'b1, 16'h0008, x, x, 1'b0, 1'b1);
         acc(1'b0, 16'h0008, 16'h0000, x, 1'b0, 1'b1);
         foreach (pa[k]) acc(1'b0, pa[k], 16'h0000, pexp(pa[k], x), 1'b0, 1'b1);
      end
      acc(1'b1, 16'h0009, v, pexp(16'h0009, x), 1'b0, 1'b1);
      acc(1'b1, 16'h001d, v, 16'h0000, 1'b1, 1'b1);
      acc(1'b0, 16'h0007, 16'h0000, 16'h001d, 1'b0, 1'b1);
      acc(1'b0, 16'h0027, 16'h0000, pexp(16'h0027, x), 1'b1, 1'b1);
      acc(1'b0, 16'h0006, 16'h0000, FAULT, 1'b0, 1'b1);
      acc(1'b0, 16'h0007, 16'h0000, 16'h0027, 1'b0, 1'b1);
      acc(1'b1, 16'h0006, v, FAULT, 1'b1, 1'b1);
      acc(1'b0, 16'h0007, 16'h0000, 16'h0006, 1'b0, 1'b1);
      acc(1'b1, 16'h0007, v, 16'h0006, 1'b1, 1'b1);
      idle();
      for (int i = 0; i < 16; i++)
      begin
         case (i % 4)
            0: f = freq_low;
            1: f = freq_high;
            2: f = freq_high + 16'h0001;
            default: f = 16'($urandom_range(1023, 0));
         endcase
         stat(f);
      end
      // second reset in mid-run clears the index pointer
      rst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      acc(1'b0, 16'h0008, 16'h0000, 16'h0000, 1'b0, 1'b1);
      idle();
      repeat (3) @(posedge sys_clk);
      check(exp_q.size() == 0, "answers missing");
      final_report();
   end
endmodule // drive_status_and_register_map_tb_top
